// File: wdt_pkg.sv
// Constants, register map and types of the watchdog / interval timer.
// Assumes one 20 MHz system clock and a synchronous tick from the watchdog oscillator.
// Overview of operation
// [R1] Watchdog mode only when the enable fuse selects it; counts independent oscillator ticks.
// [R2] In watchdog mode an unfed expiry resets the CPU; software cannot stop it.
// [R3] With the fuse clear the timer is an interval timer raising an interrupt.
// [R4] Three-bit select gives eight periods, 25 ms doubling up to 3.2 s.
// [R5] In watchdog mode the control register accepts one write only.
// [R6] Software should feed first, then write the select, within 10 ms.
// [R7] A stopped CPU clock does not stop the count, timeout or reset.
// [R8] In watchdog mode a chip reset from another source holds the timer.
// [R9] A feed is 1Eh then E1h written to the feed register.
// [R10] Other activity between the two feed writes does not break the pair.
// [R11] A wrong feed does nothing; the original expiry time stands. The code still sets EV_BADFEED.
// [R12] Timeout gives about 1 us of internal reset, then execution resumes.
// [R13] Timeout in power-down restarts the oscillator and waits for it to settle.
// [R14] A valid feed restarts the count from zero with the current period.
package wdt_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int SEL_W  = 3;
  localparam int CNT_W  = 24;
  localparam int EV_W   = 3;

  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_FEED    = 8'h01;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h02;
  localparam logic [ADDR_W-1:0] OFF_INT_CLR = 8'h03;
  localparam logic [ADDR_W-1:0] OFF_INT_EN  = 8'h04;

  localparam int CTRL_SEL_LSB  = 0;
  localparam int CTRL_RUN_BIT  = 3;
  localparam int CTRL_LOCK_BIT = 4;
  localparam int CTRL_FUSE_BIT = 5;

  localparam int EV_INTERVAL = 0;
  localparam int EV_WDT      = 1;
  localparam int EV_BADFEED  = 2;

  localparam logic [SEL_W-1:0] SEL_RESET    = 3'h7;
  localparam logic             RUN_RESET    = 1'b0;
  localparam logic [EV_W-1:0]  INT_EN_RESET = 3'h0;

  localparam logic [DATA_W-1:0] FEED_FIRST  = 8'h1e;
  localparam logic [DATA_W-1:0] FEED_SECOND = 8'he1;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int RESET_PULSE_NS  = 1000;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS / 2) / CLK_PERIOD_NS;
  localparam int PULSE_W         = 5;

  localparam int TIMEOUT_BASE_MS = 25;
  localparam int TIMEOUT_MAX_MS  = 3200;
  localparam int INIT_WINDOW_MS  = 10;
  localparam int WDT_OSC_KHZ_DEF = 400;
  localparam int BASE_TICKS_DEF  = TIMEOUT_BASE_MS * WDT_OSC_KHZ_DEF;

  typedef logic [SEL_W-1:0] sel_t;

  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_PULSE = 2'b01,
    ST_WAIT  = 2'b10
  } wdt_state_t;
endpackage : wdt_pkg

// File: wdt_count_if.sv
// Interface between the watchdog control logic and its timeout counter.
// Assumes both ends share the system clock.
`timescale 1ns/10ps
interface wdt_count_if;
  logic              tick;
  logic              restart;
  logic              hold;
  wdt_pkg::sel_t     sel;
  logic              expire;

  modport ctrl    (output tick, output restart, output hold, output sel, input expire);
  modport counter (input tick, input restart, input hold, input sel, output expire);
endinterface : wdt_count_if

// File: wdt_counter.sv
// Timeout counter, advanced by watchdog oscillator ticks.
// Assumes the tick is a one-cycle pulse synchronous to the clock.
`timescale 1ns/10ps
module wdt_counter #(
  parameter int BASE_TICKS = wdt_pkg::BASE_TICKS_DEF
) (
  input wire logic     clock,
  input wire logic     rst_n,
  wdt_count_if.counter cif
);
  import wdt_pkg::*;

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] limit;
  logic             expire_q;
  logic             at_end;

  // Period doubles with each select step [R4]
  assign limit  = CNT_W'(BASE_TICKS) << cif.sel;
  // Compare with >= so a shorter period picked mid-count still expires
  assign at_end = (count_q >= (limit - CNT_W'(1)));

  // Only the oscillator tick advances it, never the CPU clock state [R7]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
    end else if (cif.hold || cif.restart) begin
      count_q <= '0; // [R14]
    end else if (cif.tick) begin
      count_q <= at_end ? '0 : count_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= !cif.hold && !cif.restart && cif.tick && at_end;
    end
  end

  assign cif.expire = expire_q;

  property p_restart_zero;
    @(posedge clock) disable iff (!rst_n)
      cif.restart |=> (count_q == '0);
  endproperty
  a_restart_zero: assert property (p_restart_zero) // [R14]
    else $error("count not zero after feed");

  property p_expire_at_limit;
    @(posedge clock) disable iff (!rst_n)
      $rose(expire_q) |-> ($past(count_q) >= (limit - CNT_W'(1))) && (count_q == '0);
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit) // [R4]
    else $error("expiry not at selected period");
endmodule : wdt_counter

// File: wdt_interval_timer.sv
// Watchdog / interval timer: register port, feed check, reset sequencing, interrupt.
// Assumes all inputs synchronous to CLOCK; WDT_OSC_TICK pulses at the watchdog oscillator rate.
`timescale 1ns/10ps
module wdt_interval_timer #(
  parameter int BASE_TICKS = wdt_pkg::BASE_TICKS_DEF
) (
  input  wire logic                       CLOCK,
  input  wire logic                       RST_N,
  input  wire logic                       WATCHDOG_ENABLE_FUSE,
  input  wire logic                       WDT_OSC_TICK,
  input  wire logic                       CPU_CLK_RUNNING,
  input  wire logic                       POWER_DOWN,
  input  wire logic                       OSC_STABLE,
  input  wire logic                       OTHER_RESET,
  input  wire logic [wdt_pkg::ADDR_W-1:0] ADDR,
  input  wire logic [wdt_pkg::DATA_W-1:0] WDATA,
  input  wire logic                       WR,
  input  wire logic                       RD,
  output logic      [wdt_pkg::DATA_W-1:0] RDATA,
  output logic                            IRQ,
  output logic                            WDT_RESET,
  output logic                            CPU_RUN,
  output logic                            OSC_RESTART,
  output logic                            WDT_MODE
);
  import wdt_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction : hit

  wdt_count_if cif ();

  logic                       fuse_valid_q;
  logic                       fuse_q;
  sel_t                       sel_q;
  logic                       run_q;
  logic                       locked_q;
  logic                       armed_q;
  logic [EV_W-1:0]            status_q;
  logic [EV_W-1:0]            status_d;
  logic [EV_W-1:0]            int_en_q;
  logic [EV_W-1:0]            events;
  logic [EV_W-1:0]            clr_mask;
  wdt_state_t                 state_q;
  wdt_state_t                 state_d;
  logic [PULSE_W-1:0]         pulse_cnt_q;
  logic [PULSE_W-1:0]         pulse_cnt_d;
  logic                       pd_q;
  logic [DATA_W-1:0]          rdata_q;
  logic [DATA_W-1:0]          read_mux;
  logic                       irq_q;
  logic                       wdt_reset_q;
  logic                       cpu_run_q;
  logic                       osc_restart_q;
  logic                       wr_ctrl;
  logic                       wr_feed;
  logic                       feed_ok;
  logic                       feed_bad;
  logic                       ctrl_accept;
  logic                       wdt_fire;
  logic                       chip_rst;

  assign wr_ctrl = WR && hit(ADDR, OFF_CTRL);
  assign wr_feed = WR && hit(ADDR, OFF_FEED);

  // Fuse is a power-up strap: caught once, on the first edge after release [R1]
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fuse_valid_q <= 1'b0;
      fuse_q       <= 1'b0;
    end else if (!fuse_valid_q) begin
      fuse_valid_q <= 1'b1;
      fuse_q       <= WATCHDOG_ENABLE_FUSE;
    end
  end

  // Watchdog-caused chip reset also reinitialises the control state
  assign chip_rst = (state_q != ST_RUN);

  // Once locked in watchdog mode, later control writes are dropped [R5]
  assign ctrl_accept = wr_ctrl && !(fuse_q && locked_q);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sel_q    <= SEL_RESET;
      run_q    <= RUN_RESET;
      locked_q <= 1'b0;
    end else if (chip_rst) begin
      sel_q    <= SEL_RESET;
      run_q    <= RUN_RESET;
      locked_q <= 1'b0;
    end else if (ctrl_accept) begin
      sel_q    <= WDATA[CTRL_SEL_LSB +: SEL_W]; // [R4]
      run_q    <= WDATA[CTRL_RUN_BIT];
      locked_q <= fuse_q; // [R5]
    end
  end

  // Feed pair: first value arms, second completes; writes elsewhere leave it armed [R10]
  assign feed_ok  = wr_feed && armed_q && (WDATA == FEED_SECOND); // [R9]
  // Wrong value clears the arm and flags EV_BADFEED; the count keeps its old schedule [R11]
  assign feed_bad = wr_feed && !feed_ok && (WDATA != FEED_FIRST);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      armed_q <= 1'b0;
    end else if (chip_rst) begin
      armed_q <= 1'b0;
    end else if (wr_feed) begin
      armed_q <= (WDATA == FEED_FIRST); // [R9]
    end
  end

  // Counter hookup. Software has no way to stop it in watchdog mode [R2]
  assign cif.tick    = WDT_OSC_TICK; // [R1]
  assign cif.restart = feed_ok; // [R14]
  assign cif.sel     = sel_q;
  // Other reset sources hold it; in interval mode the run bit gates it too [R8]
  assign cif.hold    = !fuse_valid_q || chip_rst || OTHER_RESET || (!fuse_q && !run_q);

  assign wdt_fire = (state_q == ST_RUN) && fuse_q && cif.expire; // [R2]

  // Reset sequencing: fixed pulse, then resume or wait for the oscillator
  always_comb begin
    state_d     = state_q;
    pulse_cnt_d = pulse_cnt_q;
    case (state_q)
      ST_RUN: begin
        if (wdt_fire) begin
          state_d     = ST_PULSE;
          pulse_cnt_d = PULSE_W'(RESET_PULSE_CYC - 1); // [R12]
        end
      end
      ST_PULSE: begin
        if (pulse_cnt_q == '0) begin
          state_d = pd_q ? ST_WAIT : ST_RUN; // [R13]
        end else begin
          pulse_cnt_d = pulse_cnt_q - PULSE_W'(1);
        end
      end
      ST_WAIT: begin
        if (OSC_STABLE) begin
          state_d = ST_RUN; // [R13]
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_q     <= ST_RUN;
      pulse_cnt_q <= '0;
    end else begin
      state_q     <= state_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  // Power-down state is sampled at the moment of expiry
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pd_q <= 1'b0;
    end else if (wdt_fire) begin
      pd_q <= POWER_DOWN; // [R13]
    end
  end

  // Outputs follow the next state so they line up with the state register
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      wdt_reset_q   <= 1'b0;
      cpu_run_q     <= 1'b0;
      osc_restart_q <= 1'b0;
    end else begin
      wdt_reset_q   <= (state_d == ST_PULSE); // [R12]
      cpu_run_q     <= (state_d == ST_RUN);
      osc_restart_q <= (state_d == ST_WAIT); // [R13]
    end
  end

  // Sticky events; a set in the clearing cycle wins
  assign events[EV_INTERVAL] = !fuse_q && cif.expire; // [R3]
  assign events[EV_WDT]      = wdt_fire;
  assign events[EV_BADFEED]  = feed_bad;
  assign clr_mask = (WR && hit(ADDR, OFF_INT_CLR)) ? WDATA[EV_W-1:0] : '0;
  assign status_d = (status_q & ~clr_mask) | events;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      int_en_q <= INT_EN_RESET;
    end else if (WR && hit(ADDR, OFF_INT_EN)) begin
      int_en_q <= WDATA[EV_W-1:0];
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & int_en_q); // [R3]
    end
  end

  // Read port; feed and clear registers read as zero
  always_comb begin
    read_mux = '0;
    if (hit(ADDR, OFF_CTRL)) begin
      read_mux[CTRL_SEL_LSB +: SEL_W] = sel_q;
      read_mux[CTRL_RUN_BIT]          = run_q;
      read_mux[CTRL_LOCK_BIT]         = locked_q;
      read_mux[CTRL_FUSE_BIT]         = fuse_q;
    end else if (hit(ADDR, OFF_STATUS)) begin
      read_mux[EV_W-1:0] = status_q;
    end else if (hit(ADDR, OFF_INT_EN)) begin
      read_mux[EV_W-1:0] = int_en_q;
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= RD ? read_mux : '0;
    end
  end

  wdt_counter #(
    .BASE_TICKS (BASE_TICKS)
  ) wdt_counter_inst (
    .clock (CLOCK),
    .rst_n (RST_N),
    .cif   (cif.counter)
  );

  assign RDATA       = rdata_q;
  assign IRQ         = irq_q;
  assign WDT_RESET   = wdt_reset_q;
  assign CPU_RUN     = cpu_run_q;
  assign OSC_RESTART = osc_restart_q;
  assign WDT_MODE    = fuse_q;

  property p_fuse_fixed;
    @(posedge CLOCK) disable iff (!RST_N)
      fuse_valid_q |=> $stable(fuse_q) && fuse_valid_q;
  endproperty
  a_fuse_fixed: assert property (p_fuse_fixed) // [R1]
    else $error("mode fuse changed after power-up");

  property p_timeout_resets;
    @(posedge CLOCK) disable iff (!RST_N)
      (fuse_q && cif.expire && state_q == ST_RUN) |=> WDT_RESET && !CPU_RUN;
  endproperty
  a_timeout_resets: assert property (p_timeout_resets) // [R2]
    else $error("watchdog expiry gave no reset");

  property p_no_stop;
    @(posedge CLOCK) disable iff (!RST_N)
      (fuse_valid_q && fuse_q && !OTHER_RESET && state_q == ST_RUN) |-> !cif.hold;
  endproperty
  a_no_stop: assert property (p_no_stop) // [R2]
    else $error("watchdog held while running");

  property p_interval_irq;
    @(posedge CLOCK) disable iff (!RST_N)
      (!fuse_q && cif.expire && int_en_q[EV_INTERVAL] && !clr_mask[EV_INTERVAL])
        |=> status_q[EV_INTERVAL] ##1 IRQ && !WDT_RESET;
  endproperty
  a_interval_irq: assert property (p_interval_irq) // [R3]
    else $error("interval expiry gave no interrupt");

  property p_single_write;
    @(posedge CLOCK) disable iff (!RST_N)
      (fuse_q && locked_q && wr_ctrl && !chip_rst) |=> $stable(sel_q) && $stable(run_q);
  endproperty
  a_single_write: assert property (p_single_write) // [R5]
    else $error("control changed after lock");

  property p_cpu_clock_free;
    @(posedge CLOCK) disable iff (!RST_N)
      (fuse_q && !CPU_CLK_RUNNING && wdt_fire) |=> WDT_RESET;
  endproperty
  a_cpu_clock_free: assert property (p_cpu_clock_free) // [R7]
    else $error("no reset with CPU clock stopped");

  property p_other_reset_hold;
    @(posedge CLOCK) disable iff (!RST_N)
      (fuse_q && OTHER_RESET) |-> cif.hold ##1 !cif.expire;
  endproperty
  a_other_reset_hold: assert property (p_other_reset_hold) // [R8]
    else $error("timer active during other reset");

  property p_feed_pair;
    @(posedge CLOCK) disable iff (!RST_N)
      (wr_feed && WDATA == FEED_SECOND && armed_q) |-> cif.restart ##1 !armed_q;
  endproperty
  a_feed_pair: assert property (p_feed_pair) // [R9]
    else $error("valid feed not taken");

  property p_gap_keeps_arm;
    @(posedge CLOCK) disable iff (!RST_N)
      (armed_q && !wr_feed && !chip_rst) |=> armed_q;
  endproperty
  a_gap_keeps_arm: assert property (p_gap_keeps_arm) // [R10]
    else $error("arm lost between feed writes");

  property p_bad_feed;
    @(posedge CLOCK) disable iff (!RST_N)
      feed_bad |-> !cif.restart ##1 status_q[EV_BADFEED] && !armed_q;
  endproperty
  a_bad_feed: assert property (p_bad_feed) // [R11]
    else $error("wrong feed had an effect");

  property p_pulse_len;
    @(posedge CLOCK) disable iff (!RST_N)
      $rose(WDT_RESET) |-> ##19 WDT_RESET ##1 !WDT_RESET;
  endproperty
  a_pulse_len: assert property (p_pulse_len) // [R12]
    else $error("reset pulse length wrong");

  property p_resume;
    @(posedge CLOCK) disable iff (!RST_N)
      ($fell(WDT_RESET) && !pd_q) |-> CPU_RUN && !OSC_RESTART;
  endproperty
  a_resume: assert property (p_resume) // [R12]
    else $error("no resume after reset");

  property p_pd_wait;
    @(posedge CLOCK) disable iff (!RST_N)
      (state_q == ST_WAIT && !OSC_STABLE) |=> OSC_RESTART && !CPU_RUN;
  endproperty
  a_pd_wait: assert property (p_pd_wait) // [R13]
    else $error("resumed before oscillator stable");
endmodule : wdt_interval_timer

// File: wdt_interval_timer_tb.sv
// Self-checking bench of the watchdog / interval timer, both fuse settings.
// Assumes BASE_TICKS of 8 and one oscillator tick every fourth clock cycle.
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] %0t mismatch got %h exp %h", $time, g, e); end end
module wdt_interval_timer_tb;
  import wdt_pkg::*;
  logic              clock, rst_n, fuse, osc_tick, cpu_clk_running;
  logic              power_down, osc_stable, other_reset, wr, rd;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              irq, wdt_reset, cpu_run, osc_restart, wdt_mode;
  logic [1:0]        div;
  int                fails, samples_checked, pulses, hi_len, last_len, n, p, s, e;

  wdt_interval_timer #(.BASE_TICKS(8)) wdt_interval_timer_inst (
    .CLOCK(clock), .RST_N(rst_n), .WATCHDOG_ENABLE_FUSE(fuse), .WDT_OSC_TICK(osc_tick),
    .CPU_CLK_RUNNING(cpu_clk_running), .POWER_DOWN(power_down), .OSC_STABLE(osc_stable),
    .OTHER_RESET(other_reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .IRQ(irq), .WDT_RESET(wdt_reset), .CPU_RUN(cpu_run),
    .OSC_RESTART(osc_restart), .WDT_MODE(wdt_mode));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Free-running tick, never in phase with bus traffic on purpose
  always @(posedge clock) begin
    div      <= div + 2'h1;
    osc_tick <= (div == 2'h3);
  end

  // Pulse length is only known once the pulse has ended
  always @(posedge clock) begin
    if (wdt_reset === 1'b1) begin
      hi_len <= hi_len + 1;
    end else if (hi_len != 0) begin
      last_len <= hi_len;
      pulses   <= pulses + 1;
      hi_len   <= 0;
    end
  end

  task wrap_up;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr    <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a, input logic [7:0] x);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    `CHK(rdata, x)
  endtask : rd_reg

  function automatic logic pick(input int w);
    return (w == 0) ? irq : ((w == 1) ? wdt_reset : cpu_run);
  endfunction : pick

  // Bounded wait for a level, cycle count returned
  task wait_lvl(input int w, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(posedge clock);
      #1;
      cnt++;
    end while (pick(w) !== lvl && cnt < lim);
  endtask : wait_lvl

  task feed;
    wr_reg(OFF_FEED, FEED_FIRST);
    wr_reg(OFF_FEED, FEED_SECOND);
  endtask : feed

  task do_reset(input logic f);
    @(posedge clock);
    rst_n <= 1'b0;
    fuse  <= f;
    repeat (20) @(posedge clock);
    `CHK(cpu_run, 1'b0)
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
  endtask : do_reset

  task wd_pulse_end;
    `CHK(cpu_run, 1'b0)
    wait_lvl(1, 1'b0, 40, n);
    @(posedge clock);
    #1;
    `CHK(last_len, RESET_PULSE_CYC)
  endtask : wd_pulse_end

  task t_reset_wd;
    do_reset(1'b1);
    `CHK(wdt_mode, 1'b1)
    `CHK(cpu_run, 1'b1)
    rd_reg(OFF_CTRL, 8'h27);
    rd_reg(OFF_STATUS, 8'h00);
    rd_reg(OFF_INT_EN, 8'h00);
    rd_reg(8'h3c, 8'h00);
    rd_reg(OFF_FEED, 8'h00);
  endtask : t_reset_wd

  task t_lock;
    feed();
    wr_reg(OFF_CTRL, 8'h00);
    rd_reg(OFF_CTRL, 8'h30);
    wr_reg(OFF_CTRL, 8'h0b);
    rd_reg(OFF_CTRL, 8'h30);
  endtask : t_lock

  task t_keepalive;
    p = pulses;
    repeat (6) begin
      wr_reg(OFF_FEED, FEED_FIRST);
      rd_reg(OFF_STATUS, 8'h00);
      wr_reg(OFF_FEED, FEED_SECOND);
      repeat (12) @(posedge clock);
    end
    `CHK(pulses, p)
    wait_lvl(1, 1'b1, 60, n);
    `CHK(n inside {[8:30]}, 1'b1)
    wd_pulse_end();
    `CHK(cpu_run, 1'b1)
    rd_reg(OFF_CTRL, 8'h27);
    rd_reg(OFF_STATUS, 8'h02);
  endtask : t_keepalive

  task t_badfeed;
    wr_reg(OFF_INT_CLR, 8'h07);
    feed();
    wr_reg(OFF_CTRL, 8'h00);
    cpu_clk_running <= 1'b0;
    repeat (12) @(posedge clock);
    wr_reg(OFF_FEED, FEED_FIRST);
    wr_reg(OFF_FEED, 8'h55);
    wr_reg(OFF_FEED, FEED_SECOND);
    wait_lvl(1, 1'b1, 60, n);
    `CHK(n inside {[1:20]}, 1'b1)
    wd_pulse_end();
    @(posedge clock);
    cpu_clk_running <= 1'b1;
    rd_reg(OFF_STATUS, 8'h06);
  endtask : t_badfeed

  task t_other;
    feed();
    wr_reg(OFF_CTRL, 8'h00);
    p = pulses;
    other_reset <= 1'b1;
    repeat (100) @(posedge clock);
    `CHK(pulses, p)
    other_reset <= 1'b0;
    wait_lvl(1, 1'b1, 60, n);
    `CHK(n inside {[20:44]}, 1'b1)
    wd_pulse_end();
  endtask : t_other

  task t_pdown;
    feed();
    wr_reg(OFF_CTRL, 8'h00);
    power_down <= 1'b1;
    osc_stable <= 1'b0;
    wait_lvl(1, 1'b1, 60, n);
    wd_pulse_end();
    `CHK(osc_restart, 1'b1)
    repeat (10) @(posedge clock);
    #1;
    `CHK(cpu_run, 1'b0)
    @(posedge clock);
    osc_stable <= 1'b1;
    power_down <= 1'b0;
    wait_lvl(2, 1'b1, 4, n);
    `CHK(cpu_run, 1'b1)
    `CHK(osc_restart, 1'b0)
  endtask : t_pdown

  // Every select measured; period doubles from the base count
  task t_interval;
    do_reset(1'b0);
    `CHK(wdt_mode, 1'b0)
    rd_reg(OFF_CTRL, 8'h07);
    wr_reg(OFF_INT_EN, 8'h01);
    p = pulses;
    for (s = 0; s < 8; s++) begin
      wr_reg(OFF_CTRL, 8'h08 | s[7:0]);
      feed();
      wr_reg(OFF_INT_CLR, 8'h07);
      wait_lvl(0, 1'b1, 5000, n);
      e = (8 << s) * 4;
      `CHK(n inside {[e - 12:e + 8]}, 1'b1)
    end
    `CHK(pulses, p)
    rd_reg(OFF_STATUS, 8'h01);
    wr_reg(OFF_INT_EN, 8'h00);
    @(posedge clock);
    #1;
    `CHK(irq, 1'b0)
    wr_reg(OFF_INT_EN, 8'h01);
    @(posedge clock);
    #1;
    `CHK(irq, 1'b1)
    wr_reg(OFF_INT_CLR, 8'h01);
    @(posedge clock);
    #1;
    `CHK(irq, 1'b0)
  endtask : t_interval

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    fuse = 1'b1;
    div = 2'h0;
    osc_tick = 1'b0;
    cpu_clk_running = 1'b1;
    power_down = 1'b0;
    osc_stable = 1'b1;
    other_reset = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    fails = 0;
    samples_checked = 0;
    pulses = 0;
    hi_len = 0;
    last_len = 0;
    t_reset_wd();
    t_lock();
    t_keepalive();
    t_badfeed();
    t_other();
    t_pdown();
    t_interval();
    wrap_up();
  end
endmodule : wdt_interval_timer_tb
